// [src/fan_cfg_pkg.sv]
// Package for the fan and sensor configuration bank.
// Assumes a single 40 MHz core clock and byte-wide register port.
package fan_cfg_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] battery_monitor_fan_sensor_ctrl_addr = 8'h5d;
  localparam logic [7:0] critical_temp_current_mode_enable_addr = 8'h5e;
  localparam logic [7:0] processor_fan_max_output_addr = 8'h67;
  localparam logic [7:0] processor_fan_output_step_addr = 8'h68;
  localparam logic [7:0] chassis_fan_critical_temp_addr = 8'h6b;
  localparam logic [7:0] processor_fan_critical_temp_addr = 8'h6c;
  localparam logic [7:0] fan_mode_ctrl_addr = 8'h70;
  localparam logic [7:0] fan_status_addr = 8'h71;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int proc_div_high_bit_pos = 6;
  localparam int chas_div_high_bit_pos = 5;
  localparam int proc_type_pos = 2;
  localparam int chas_type_pos = 1;
  localparam int battery_enable_pos = 0;
  localparam int proc_crit_enable_pos = 5;
  localparam int chas_crit_enable_pos = 4;
  localparam int proc_current_mode_pos = 2;
  localparam int chas_current_mode_pos = 1;
  // Writable masks: reserved bits read zero
  localparam logic [7:0] ctrl_mask = 8'h67;
  localparam logic [7:0] crit_mask = 8'h36;
  localparam logic [7:0] mode_mask = 8'h03;
  // ----------------------------------------
  // Reset values and full drive level
  // ----------------------------------------
  localparam logic [7:0] ctrl_reset = 8'h04;
  localparam logic [7:0] crit_reset = 8'h04;
  localparam logic [7:0] max_output_reset = 8'hff;
  localparam logic [7:0] step_reset = 8'h01;
  localparam logic [7:0] crit_temp_reset = 8'hff;
  localparam logic [7:0] mode_reset = 8'h00;
  localparam logic [7:0] full_drive = 8'hff;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int clk_period_ns = 25;
  localparam int monitor_cycle_us = 100;
  localparam int monitor_cycle_cycles = (monitor_cycle_us * 1000) / clk_period_ns;
  // Sensing modes per temperature input
  typedef enum logic [1:0] {
    sense_thermistor = 2'h0,
    sense_diode = 2'h1,
    sense_current = 2'h2
  } sense_mode_t;
  // Fan control modes
  typedef enum logic [1:0] {
    fan_manual = 2'h0,
    fan_stepwise = 2'h1,
    fan_temp_target = 2'h2
  } fan_mode_t;
endpackage

// [src/fan_step_if.sv]
// Interface between the bank and its stepwise fan stepper.
// Assumes both ends share core_clk_in.
`timescale 1ns/1ps
interface fan_step_if;
  logic adjust_up;
  logic adjust_down;
  logic [7:0] max_value;
  logic [7:0] step_value;
  logic [7:0] drive_value;
  modport bank(output adjust_up, output adjust_down, output max_value, output step_value,
    input drive_value);
  modport stepper(input adjust_up, input adjust_down, input max_value, input step_value,
    output drive_value);
endinterface

// [src/fan_stepper.sv]
// Stepwise fan drive value generator.
// Assumes one-cycle adjust requests from the bank on the same clock.
`timescale 1ns/1ps
module fan_stepper
  import fan_cfg_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Bank side
  fan_step_if.stepper step
);
  logic [8:0] next_sum;
  always_comb begin
    next_sum = {1'b0, step.drive_value} + {1'b0, step.step_value};
  end
  // ----------------------------------------
  // Drive value
  // ----------------------------------------
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      step.drive_value <= 8'h00;
    end else if (step.adjust_up) begin
      // Clamp at the maximum, never wrap
      if (next_sum > {1'b0, step.max_value}) begin
        step.drive_value <= step.max_value;
      end else begin
        step.drive_value <= next_sum[7:0];
      end
    end else if (step.adjust_down) begin
      // Floor at zero
      if (step.drive_value < step.step_value) begin
        step.drive_value <= 8'h00;
      end else begin
        step.drive_value <= step.drive_value - step.step_value;
      end
    end else if (step.drive_value > step.max_value) begin
      // Maximum lowered by software
      step.drive_value <= step.max_value;
    end
  end
endmodule

// [src/fan_sensor_config_bank.sv]
// Fan and temperature-sensor configuration register bank.
// Assumes a byte register port on the 40 MHz core clock, temperature and step pins synchronised here.
`timescale 1ns/1ps
module fan_sensor_config_bank
  import fan_cfg_pkg::*;
#(
  parameter int monitor_cycles = monitor_cycle_cycles
)(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Fan speed divisor low bits and resulting divisor
  input wire logic [1:0] proc_div_low_in,
  input wire logic [1:0] chas_div_low_in,
  output logic [7:0] proc_fan_divisor_out,
  output logic [7:0] chas_fan_divisor_out,
  // Sensing mode selects
  output logic [1:0] proc_sense_mode_out,
  output logic [1:0] chas_sense_mode_out,
  // Battery monitor
  output logic battery_monitor_enable_out,
  output logic battery_reading_update_out,
  // Temperatures and fan control
  input wire logic [7:0] proc_temp_in,
  input wire logic [7:0] chas_temp_in,
  input wire logic proc_step_up_in,
  input wire logic proc_step_down_in,
  input wire logic [7:0] proc_target_drive_in,
  input wire logic [7:0] chas_target_drive_in,
  output logic [7:0] processor_fan_drive_output,
  output logic [7:0] chassis_fan_drive_output
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] battery_monitor_fan_sensor_ctrl;
  logic [7:0] critical_temp_current_mode_enable;
  logic [7:0] processor_fan_max_output;
  logic [7:0] processor_fan_output_step;
  logic [7:0] chassis_fan_critical_temp;
  logic [7:0] processor_fan_critical_temp;
  logic [7:0] fan_mode_ctrl;
  logic [7:0] next_rdata;
  fan_mode_t fan_mode;
  fan_step_if step_link();

  // Temperature and step pins pass two flops before use
  logic [7:0] proc_temp_meta, proc_temp_sync;
  logic [7:0] chas_temp_meta, chas_temp_sync;
  logic [1:0] step_meta, step_sync, step_prev;

  function automatic logic [7:0] divisor_of(input logic [2:0] code);
    divisor_of = 8'h01 << code;
  endfunction

  function automatic logic [1:0] sense_of(input logic current_bit, input logic type_bit);
    if (current_bit) begin
      sense_of = sense_current;
    end else if (type_bit) begin
      sense_of = sense_diode;
    end else begin
      sense_of = sense_thermistor;
    end
  endfunction

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  function automatic logic write_hit(input logic strobe, input logic [7:0] addr,
    input logic [7:0] offset);
    write_hit = strobe && (addr == offset);
  endfunction

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      battery_monitor_fan_sensor_ctrl <= ctrl_reset;
    end else if (write_hit(wr_in, addr_in, battery_monitor_fan_sensor_ctrl_addr)) begin
      battery_monitor_fan_sensor_ctrl <= wdata_in & ctrl_mask;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      critical_temp_current_mode_enable <= crit_reset;
    end else if (write_hit(wr_in, addr_in, critical_temp_current_mode_enable_addr)) begin
      critical_temp_current_mode_enable <= wdata_in & crit_mask;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      processor_fan_max_output <= max_output_reset;
    end else if (write_hit(wr_in, addr_in, processor_fan_max_output_addr)) begin
      // Zero or below-stop values are software's to avoid
      processor_fan_max_output <= wdata_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      processor_fan_output_step <= step_reset;
    end else if (write_hit(wr_in, addr_in, processor_fan_output_step_addr)) begin
      processor_fan_output_step <= wdata_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      chassis_fan_critical_temp <= crit_temp_reset;
    end else if (write_hit(wr_in, addr_in, chassis_fan_critical_temp_addr)) begin
      chassis_fan_critical_temp <= wdata_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      processor_fan_critical_temp <= crit_temp_reset;
    end else if (write_hit(wr_in, addr_in, processor_fan_critical_temp_addr)) begin
      processor_fan_critical_temp <= wdata_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fan_mode_ctrl <= mode_reset;
    end else if (write_hit(wr_in, addr_in, fan_mode_ctrl_addr)) begin
      fan_mode_ctrl <= wdata_in & mode_mask;
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always_comb begin
    case (addr_in)
      battery_monitor_fan_sensor_ctrl_addr: next_rdata = battery_monitor_fan_sensor_ctrl;
      critical_temp_current_mode_enable_addr: next_rdata = critical_temp_current_mode_enable;
      processor_fan_max_output_addr: next_rdata = processor_fan_max_output;
      processor_fan_output_step_addr: next_rdata = processor_fan_output_step;
      chassis_fan_critical_temp_addr: next_rdata = chassis_fan_critical_temp;
      processor_fan_critical_temp_addr: next_rdata = processor_fan_critical_temp;
      fan_mode_ctrl_addr: next_rdata = fan_mode_ctrl;
      fan_status_addr: next_rdata = step_link.drive_value;
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      rdata_out <= next_rdata;
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      proc_temp_meta <= 8'h00;
      proc_temp_sync <= 8'h00;
      chas_temp_meta <= 8'h00;
      chas_temp_sync <= 8'h00;
      step_meta <= 2'h0;
      step_sync <= 2'h0;
      step_prev <= 2'h0;
    end else begin
      proc_temp_meta <= proc_temp_in;
      proc_temp_sync <= proc_temp_meta;
      chas_temp_meta <= chas_temp_in;
      chas_temp_sync <= chas_temp_meta;
      step_meta <= {proc_step_up_in, proc_step_down_in};
      step_sync <= step_meta;
      step_prev <= step_sync;
    end
  end

  // ----------------------------------------
  // Temperature words
  // ----------------------------------------
  // Word taken only when two samples agree, so a skewed change never compares
  logic [7:0] proc_temp_prev, proc_temp_used;
  logic [7:0] chas_temp_prev, chas_temp_used;
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      proc_temp_prev <= 8'h00;
      proc_temp_used <= 8'h00;
      chas_temp_prev <= 8'h00;
      chas_temp_used <= 8'h00;
    end else begin
      proc_temp_prev <= proc_temp_sync;
      chas_temp_prev <= chas_temp_sync;
      if (proc_temp_sync == proc_temp_prev) begin
        proc_temp_used <= proc_temp_sync;
      end
      if (chas_temp_sync == chas_temp_prev) begin
        chas_temp_used <= chas_temp_sync;
      end
    end
  end

  // ----------------------------------------
  // Divisors and sensing modes
  // ----------------------------------------
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      proc_fan_divisor_out <= 8'h01;
      chas_fan_divisor_out <= 8'h01;
      proc_sense_mode_out <= 2'h0;
      chas_sense_mode_out <= 2'h0;
    end else begin
      proc_fan_divisor_out <= divisor_of({battery_monitor_fan_sensor_ctrl[proc_div_high_bit_pos],
        proc_div_low_in});
      chas_fan_divisor_out <= divisor_of({battery_monitor_fan_sensor_ctrl[chas_div_high_bit_pos],
        chas_div_low_in});
      // Current mode outranks the type bit
      proc_sense_mode_out <= sense_of(critical_temp_current_mode_enable[proc_current_mode_pos],
        battery_monitor_fan_sensor_ctrl[proc_type_pos]);
      chas_sense_mode_out <= sense_of(critical_temp_current_mode_enable[chas_current_mode_pos],
        battery_monitor_fan_sensor_ctrl[chas_type_pos]);
    end
  end

  // ----------------------------------------
  // Battery monitor
  // ----------------------------------------
  logic [31:0] monitor_count;
  logic battery_en_prev;
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      battery_monitor_enable_out <= 1'b0;
    end else begin
      battery_monitor_enable_out <= battery_monitor_fan_sensor_ctrl[battery_enable_pos];
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      monitor_count <= 32'h0;
      battery_en_prev <= 1'b0;
      battery_reading_update_out <= 1'b0;
    end else begin
      battery_en_prev <= battery_monitor_fan_sensor_ctrl[battery_enable_pos];
      battery_reading_update_out <= 1'b0;
      if (!battery_monitor_fan_sensor_ctrl[battery_enable_pos]) begin
        monitor_count <= 32'h0;
      end else if (!battery_en_prev) begin
        // Rising enable restarts a full cycle, so no stale reading posts
        monitor_count <= 32'h0;
      end else if (monitor_count == 32'(monitor_cycles - 1)) begin
        monitor_count <= 32'h0;
        battery_reading_update_out <= 1'b1;
      end else begin
        monitor_count <= monitor_count + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // Stepwise mode
  // ----------------------------------------
  always_comb begin
    fan_mode = fan_mode_t'(fan_mode_ctrl[1:0]);
    // Edge of a held request counts once, so one step per adjustment
    step_link.adjust_up = (fan_mode == fan_stepwise) && step_sync[1] && !step_prev[1];
    step_link.adjust_down = (fan_mode == fan_stepwise) && step_sync[0] && !step_prev[0]
      && !step_sync[1];
    step_link.max_value = processor_fan_max_output;
    step_link.step_value = processor_fan_output_step;
  end

  fan_stepper stepper_inst (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .step(step_link.stepper)
  );

  // ----------------------------------------
  // Fan outputs
  // ----------------------------------------
  logic proc_crit_hit;
  logic chas_crit_hit;
  always_comb begin
    proc_crit_hit = critical_temp_current_mode_enable[proc_crit_enable_pos]
      && (proc_temp_used > processor_fan_critical_temp);
    chas_crit_hit = critical_temp_current_mode_enable[chas_crit_enable_pos]
      && (chas_temp_used > chassis_fan_critical_temp);
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      processor_fan_drive_output <= 8'h00;
    end else begin
      case (fan_mode)
        fan_stepwise: begin
          processor_fan_drive_output <= step_link.drive_value;
        end
        fan_temp_target: begin
          // Full drive overrides, else back to normal value
          processor_fan_drive_output <= proc_crit_hit ? full_drive : proc_target_drive_in;
        end
        default: begin
          processor_fan_drive_output <= proc_target_drive_in;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      chassis_fan_drive_output <= 8'h00;
    end else begin
      case (fan_mode)
        fan_temp_target: begin
          // Full drive overrides, else back to normal value
          chassis_fan_drive_output <= chas_crit_hit ? full_drive : chas_target_drive_in;
        end
        default: begin
          chassis_fan_drive_output <= chas_target_drive_in;
        end
      endcase
    end
  end
endmodule

// [tb/fan_bank_sva.sv]
// Port assertions for the fan and sensor configuration bank.
// Assumes binding onto the bank; sees only its ports.
`timescale 1ns/1ps
module fan_bank_sva
  import fan_cfg_pkg::*;
#(
  parameter int monitor_cycles = 8
)(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  // Divisors and sensing
  input wire logic [7:0] proc_fan_divisor_out,
  input wire logic [7:0] chas_fan_divisor_out,
  input wire logic [1:0] proc_sense_mode_out,
  input wire logic [1:0] chas_sense_mode_out,
  // Battery monitor
  input wire logic battery_monitor_enable_out,
  input wire logic battery_reading_update_out
);
  // ----
  // Checks
  // ----
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence rd_at(logic [7:0] a);
    rd_in && addr_in == a;
  endsequence
  sequence wr_at(logic [7:0] a);
    wr_in && addr_in == a;
  endsequence
  AST_RDATA_IDLE: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data not idle");
  AST_PROC_DIV: assert property ($onehot(proc_fan_divisor_out))
    else $error("processor divisor not a power of two");
  AST_CHAS_DIV: assert property ($onehot(chas_fan_divisor_out))
    else $error("chassis divisor not a power of two");
  AST_SENSE_LEGAL: assert property (proc_sense_mode_out != 2'h3)
    else $error("bad processor sense mode");
  AST_BATT_EN: assert property (battery_reading_update_out |-> battery_monitor_enable_out)
    else $error("battery update while disabled");
  AST_BATT_FIRST: assert property ($rose(battery_monitor_enable_out) |->
    !battery_reading_update_out [*7])
    else $error("battery update too early");
  AST_BATT_PULSE: assert property (battery_reading_update_out |=>
    !battery_reading_update_out)
    else $error("battery update longer than a cycle");
  AST_STEP_RDBACK: assert property (wr_at(processor_fan_output_step_addr) ##1
    rd_at(processor_fan_output_step_addr) |=> rdata_out == $past(wdata_in, 2))
    else $error("step value lost");
  AST_CRIT_RDBACK: assert property (wr_at(critical_temp_current_mode_enable_addr) ##1
    rd_at(critical_temp_current_mode_enable_addr) |=>
    rdata_out == ($past(wdata_in, 2) & crit_mask))
    else $error("critical enable lost");
endmodule
bind fan_sensor_config_bank fan_bank_sva #(.monitor_cycles(monitor_cycles)) i_sva (.*);

// [tb/tb_fan_sensor_config_bank.sv]
// Self-checking bench for the fan and sensor configuration bank.
// Assumes the bound checker; monitor count shortened to 8.
`timescale 1ns/1ps
module tb_fan_sensor_config_bank;
  import fan_cfg_pkg::*;
  logic core_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [1:0] proc_div_low_in = 2'h0;
  logic [1:0] chas_div_low_in = 2'h0;
  logic [7:0] proc_temp_in = 8'h00;
  logic [7:0] chas_temp_in = 8'h00;
  logic proc_step_up_in = 1'b0;
  logic proc_step_down_in = 1'b0;
  logic [7:0] proc_target_drive_in = 8'h00;
  logic [7:0] chas_target_drive_in = 8'h00;
  logic [7:0] rdata_out, proc_fan_divisor_out, chas_fan_divisor_out;
  logic [1:0] proc_sense_mode_out, chas_sense_mode_out;
  logic battery_monitor_enable_out, battery_reading_update_out;
  logic [7:0] processor_fan_drive_output, chassis_fan_drive_output;
  int err_total = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'd61;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic [7:0] ra[8] = '{8'h5d, 8'h5e, 8'h67, 8'h68, 8'h6b, 8'h6c, 8'h70, 8'h00};
  logic [7:0] rv[8] = '{8'h04, 8'h04, 8'hff, 8'h01, 8'hff, 8'hff, 8'h00, 8'h00};
  logic [7:0] msk[8] = '{8'h67, 8'h36, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03, 8'h00};
  logic [1:0] te[5] = '{2'h0, 2'h3, 2'h3, 2'h1, 2'h2};
  logic [7:0] tp[5] = '{8'hff, 8'h61, 8'h60, 8'hff, 8'hff};
  logic [7:0] tc[5] = '{8'hff, 8'h50, 8'h51, 8'hff, 8'hff};
  logic [7:0] d;
  int n;
  int dv;
  fan_sensor_config_bank #(.monitor_cycles(8)) i_dut (.*);
  always #12.5 core_clk_in = ~core_clk_in;
  // ----
  // Helpers
  // ----
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    num_checks++;
    if (seen !== want) begin
      err_total++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  // Bus tasks start just after an edge and leave strobes up for the next task
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    rd_in <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    exp_q.push_back(want);
    addr_in <= a;
    rd_in <= 1'b1;
    wr_in <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task automatic idle(input int c);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    repeat (c) @(posedge core_clk_in);
  endtask
  task automatic finish_test();
    if (err_total == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Read data compared against the oldest note, one cycle after the strobe
  always @(posedge core_clk_in) begin
    if (rd_seen) chk(rdata_out, exp_q.pop_front());
    rd_seen <= rd_in;
  end
  initial begin
    repeat (5000) @(posedge core_clk_in);
    err_total++;
    finish_test();
  end
  // ----
  // Scenarios
  // ----
  initial begin
    repeat (2) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    @(posedge core_clk_in);
    for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
    idle(1);
    chk(8'(proc_sense_mode_out), 8'h02);
    chk(8'(chas_sense_mode_out), 8'h00);
    for (int i = 0; i < 8; i++) begin
      d = rnd();
      if (i == 0) d = d | 8'h06;
      if (i == 2) d = d | 8'h80;
      wr(ra[i], d);
      rd(ra[i], d & msk[i]);
    end
    for (int c = 0; c < 8; c++) begin
      wr(8'h5d, {1'b0, c[2], ~c[2], 5'h06});
      proc_div_low_in <= c[1:0];
      chas_div_low_in <= ~c[1:0];
      idle(4);
      chk(proc_fan_divisor_out, 8'h01 << c);
      chk(chas_fan_divisor_out, 8'h01 << (7 - c));
    end
    for (int k = 0; k < 8; k++) begin
      wr(8'h5d, {5'h00, k[0] | k[1], k[1] | k[2], 1'b0});
      wr(8'h5e, {5'h00, k[1], k[2], 1'b0});
      idle(4);
      chk(8'(proc_sense_mode_out), k[1] ? 8'h02 : 8'(k[0]));
      chk(8'(chas_sense_mode_out), k[2] ? 8'h02 : 8'(k[1]));
    end
    wr(8'h5d, 8'h07);
    idle(1);
    n = 0;
    while (battery_reading_update_out !== 1'b1 && n < 30) begin
      @(posedge core_clk_in);
      n++;
    end
    chk(8'(n >= 6 && n <= 9), 8'h01);
    wr(8'h5d, 8'h06);
    idle(2);
    n = 0;
    repeat (20) begin
      @(posedge core_clk_in);
      if (battery_reading_update_out !== 1'b0) n++;
    end
    chk(8'(n), 8'h00);
    // Stepper: up three times hits the ceiling, then one step down
    wr(8'h70, 8'h01);
    wr(8'h68, 8'h30);
    wr(8'h67, 8'h70);
    idle(1);
    dv = 0;
    for (int s = 0; s < 4; s++) begin
      proc_step_up_in <= (s < 3);
      proc_step_down_in <= (s == 3);
      idle(3);
      proc_step_up_in <= 1'b0;
      proc_step_down_in <= 1'b0;
      idle(6);
      dv = (s < 3) ? ((dv + 8'h30 > 8'h70) ? 8'h70 : dv + 8'h30) : dv - 8'h30;
      rd(8'h71, 8'(dv));
    end
    idle(2);
    chk(processor_fan_drive_output, 8'(dv));
    wr(8'h70, 8'h02);
    wr(8'h6b, 8'h50);
    wr(8'h6c, 8'h60);
    proc_target_drive_in <= rnd();
    chas_target_drive_in <= rnd();
    for (int t = 0; t < 5; t++) begin
      wr(8'h5e, {2'h0, te[t], 4'h4});
      proc_temp_in <= tp[t];
      chas_temp_in <= tc[t];
      idle(7);
      chk(processor_fan_drive_output,
        (te[t][1] && tp[t] > 8'h60) ? 8'hff : proc_target_drive_in);
      chk(chassis_fan_drive_output,
        (te[t][0] && tc[t] > 8'h50) ? 8'hff : chas_target_drive_in);
    end
    wr(8'h70, 8'h00);
    idle(3);
    chk(processor_fan_drive_output, proc_target_drive_in);
    chk(chassis_fan_drive_output, chas_target_drive_in);
    finish_test();
  end
endmodule
